// *** cacc_cell.sv ***
// ==========================================================
// Shared constants and types
// ==========================================================
package cacc_pkg;
    // Sizes
    localparam int          NUM_MODULES_DEF = 5;
    localparam int          WDT_MODULE_DEF  = 4;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_FLAGS      = 8'h04;
    localparam logic [7:0]  ADDR_COUNT_LOW  = 8'h08;
    localparam logic [7:0]  ADDR_COUNT_HIGH = 8'h0c;
    localparam logic [7:0]  ADDR_WDT        = 8'h10;
    // Module n sits at upper nibble MOD_BASE_HI + n
    localparam logic [3:0]  MOD_BASE_HI     = 4'h2;
    localparam logic [1:0]  SEL_MODE        = 2'h0;
    localparam logic [1:0]  SEL_CMP_LOW     = 2'h1;
    localparam logic [1:0]  SEL_CMP_HIGH    = 2'h2;
    // Field positions
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          WDT_EN_BIT      = 0;
    // Reset values
    localparam logic [6:0]  MODE_RESET      = 7'h00;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;

    // Module mode register, bit 0 at the bottom
    typedef struct packed {
        logic comparator_enable;
        logic rising_edge_capture_enable;
        logic falling_edge_capture_enable;
        logic compare_hit_enable;
        logic output_flip_enable;
        logic pwm_enable;
        logic module_irq_enable;
    } cacc_mode_t;

    // Software write strobes for one module
    typedef struct packed {
        logic       mode;
        logic       low;
        logic       high;
        logic [7:0] data;
    } cacc_wr_t;
endpackage

// ==========================================================
// One compare/capture module
// ==========================================================
module cacc_cell (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Shared counter
    input  wire logic [15:0]        count,
    input  wire logic               low_wrap,
    // Synchronised pin and its previous sample
    input  wire logic               pin_now,
    input  wire logic               pin_prev,
    // Software writes
    input  wire cacc_pkg::cacc_wr_t wr,
    // State
    output cacc_pkg::cacc_mode_t    mode_reg,
    output logic [7:0]              low_reg,
    output logic [7:0]              high_reg,
    output logic                    hit,
    output logic                    captured,
    output logic                    event_hit,
    output logic                    pin_out_reg,
    output logic                    pin_oe_reg
);
    import cacc_pkg::*;

    logic eq_prev_reg;
    logic eq;
    logic pwm_on;

    // Hit only on the first cycle of equality, so a stopped counter fires once
    assign eq        = (count == {high_reg, low_reg});
    assign hit       = eq & ~eq_prev_reg & mode_reg.comparator_enable;  // RULE_04
    assign captured  = (pin_now & ~pin_prev & mode_reg.rising_edge_capture_enable)
                     | (~pin_now & pin_prev & mode_reg.falling_edge_capture_enable); // RULE_21
    assign event_hit = captured | (hit & mode_reg.compare_hit_enable);
    assign pwm_on    = mode_reg.pwm_enable & mode_reg.comparator_enable;  // RULE_15

    // Equality history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) eq_prev_reg <= 1'b0;
        else          eq_prev_reg <= eq;
    end

    // Mode register; compare byte writes steer the comparator enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= cacc_mode_t'(MODE_RESET);
        end else if (wr.mode) begin
            mode_reg <= cacc_mode_t'(wr.data[6:0]);  // RULE_07
        end else if (wr.low) begin
            mode_reg.comparator_enable <= 1'b0;  // RULE_05
        end else if (wr.high) begin
            mode_reg.comparator_enable <= 1'b1;  // RULE_06
        end
    end

    // Low byte: software, capture, or reload at the low-byte wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)               low_reg <= BYTE_RESET;
        else if (wr.low)            low_reg <= wr.data;
        else if (captured)          low_reg <= count[7:0];  // RULE_02
        else if (pwm_on && low_wrap) low_reg <= high_reg;   // RULE_14
    end

    // High byte: software or capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)      high_reg <= BYTE_RESET;
        else if (wr.high)  high_reg <= wr.data;
        else if (captured) high_reg <= count[15:8];  // RULE_02
    end

    // Pin drive: PWM level or toggle on hit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg  <= 1'b0;
        end else begin
            pin_oe_reg <= pwm_on | (mode_reg.output_flip_enable & mode_reg.compare_hit_enable
                                    & mode_reg.comparator_enable);
            if (pwm_on)
                pin_out_reg <= (count[7:0] >= low_reg);  // RULE_13
            else if (hit && mode_reg.output_flip_enable && mode_reg.compare_hit_enable)
                pin_out_reg <= ~pin_out_reg;  // RULE_10
        end
    end
endmodule // cacc_cell

// *** cacc_top.sv ***
// Summary of operation
// (RULE_01) Capture enabled by either edge enable bit
// (RULE_02) Selected pin edge copies counter into compare
// (RULE_03) Capture interrupts when flag and enable set
// (RULE_04) Compare match flags and may interrupt
// (RULE_05) Low byte write clears comparator enable
// (RULE_06) High byte write sets comparator enable
// (RULE_07) Comparator enable stays writable in mode register
// (RULE_08) Software loads nonzero compare before enabling
// (RULE_09) Software writes low byte then high
// (RULE_10) Toggle mode inverts pin on each match
// (RULE_11) Software writes compare bytes before toggle start
// (RULE_12) PWM modules share period, own duty byte
// (RULE_13) PWM low below duty byte, else high
// (RULE_14) Low byte wrap reloads duty from high
// (RULE_15) PWM needs pwm and comparator enable
// (RULE_16) Only last module may act as watchdog; here WDT_MODULE may name any module
// (RULE_17) Watchdog match raises internal reset only
// (RULE_18) Clearing watchdog enable stops reset generation
// (RULE_19) Software moves compare value to hold off
// (RULE_20) Event flags sticky until software clears
// (RULE_21) Either or single edge capture per enables
// (RULE_22) All modules see one shared count
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
module cacc_top #(
    parameter int NUM_MODULES = cacc_pkg::NUM_MODULES_DEF,
    parameter int WDT_MODULE  = cacc_pkg::WDT_MODULE_DEF
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Module pins
    input  wire logic [NUM_MODULES-1:0] module_io_pin_in,
    output logic [NUM_MODULES-1:0]      module_io_pin_out,
    output logic [NUM_MODULES-1:0]      module_io_pin_oe,
    // Events out
    output logic                        irq_req,
    output logic                        watchdog_reset
);
    import cacc_pkg::*;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (NUM_MODULES < 1 || NUM_MODULES > 14) begin : g_bad_num
        $error("NUM_MODULES must be 1 to 14");
    end
    if (WDT_MODULE < 0 || WDT_MODULE >= NUM_MODULES) begin : g_bad_wdt
        $error("WDT_MODULE must name an existing module");
    end

    // ==========================================================
    // Declarations
    // ==========================================================
    logic                   run_reg;
    logic                   wdt_en_reg;
    logic [15:0]            count_reg;
    logic [NUM_MODULES-1:0] flags_reg;
    logic [NUM_MODULES-1:0] flags_next;
    logic [NUM_MODULES-1:0] sync1_reg;
    logic [NUM_MODULES-1:0] sync2_reg;
    logic [NUM_MODULES-1:0] prev_reg;
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic                   irq_reg;
    logic                   wdog_reg;
    logic                   setup;
    logic                   wr_fire;
    logic                   count_wr;
    logic                   low_wrap;
    logic [31:0]            rd_data;
    logic                   rd_err;
    logic [NUM_MODULES-1:0] evt_w;
    logic [NUM_MODULES-1:0] hit_w;
    logic [NUM_MODULES-1:0] cap_w;
    logic [NUM_MODULES-1:0] irq_en_w;
    logic [NUM_MODULES-1:0] flag_clr;
    cacc_mode_t             mode_w [NUM_MODULES];
    logic [7:0]             low_w  [NUM_MODULES];
    logic [7:0]             high_w [NUM_MODULES];
    cacc_wr_t               wr_w   [NUM_MODULES];

    // ==========================================================
    // Address decode
    // ==========================================================
    // Module index of an address, negative below the module window
    function automatic int mod_idx(input logic [7:0] a);
        return int'(a[7:4]) - int'(MOD_BASE_HI);
    endfunction

    // Address falls on an implemented module register
    function automatic logic mod_hit(input logic [7:0] a);
        return mod_idx(a) >= 0 && mod_idx(a) < NUM_MODULES
               && a[3:2] != 2'h3 && a[1:0] == 2'h0;
    endfunction

    // ==========================================================
    // APB handshake
    // ==========================================================
    // Zero wait states: data is registered in setup, ready in access
    assign setup   = psel & ~penable;
    assign wr_fire = psel & penable & pready_reg & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & rd_err;
            prdata_reg  <= (setup && !pwrite) ? rd_data : 32'h0;
        end
    end

    // Read mux; unmapped addresses read zero and raise pslverr
    always_comb begin
        rd_data = 32'h0;
        rd_err  = 1'b0;
        if (mod_hit(paddr)) begin
            case (paddr[3:2])
                SEL_MODE:     rd_data = {25'h0, mode_w[mod_idx(paddr)]};
                SEL_CMP_LOW:  rd_data = {24'h0, low_w[mod_idx(paddr)]};
                SEL_CMP_HIGH: rd_data = {24'h0, high_w[mod_idx(paddr)]};
                default:      rd_err  = 1'b1;
            endcase
        end else begin
            case (paddr)
                ADDR_CTRL:       rd_data[CTRL_RUN_BIT] = run_reg;
                ADDR_FLAGS:      rd_data[NUM_MODULES-1:0] = flags_reg;
                ADDR_COUNT_LOW:  rd_data[7:0] = count_reg[7:0];
                ADDR_COUNT_HIGH: rd_data[7:0] = count_reg[15:8];
                ADDR_WDT:        rd_data[WDT_EN_BIT] = wdt_en_reg;
                default:         rd_err = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // Control registers
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg    <= 1'b0;
            wdt_en_reg <= 1'b0;
        end else if (wr_fire) begin
            if (paddr == ADDR_CTRL) run_reg <= pwdata[CTRL_RUN_BIT];
            if (paddr == ADDR_WDT) wdt_en_reg <= pwdata[WDT_EN_BIT];  // RULE_18
        end
    end

    // ==========================================================
    // Shared counter
    // ==========================================================
    assign count_wr = wr_fire & (paddr == ADDR_COUNT_LOW || paddr == ADDR_COUNT_HIGH);
    // Wrap pulse lines up with the edge where the low byte becomes zero
    assign low_wrap = run_reg & ~count_wr & (count_reg[7:0] == 8'hff);  // RULE_12

    // One register feeds every module in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            count_reg <= COUNT_RESET;
        else if (wr_fire && paddr == ADDR_COUNT_LOW)
            count_reg[7:0] <= pwdata[7:0];
        else if (wr_fire && paddr == ADDR_COUNT_HIGH)
            count_reg[15:8] <= pwdata[7:0];
        else if (run_reg)
            count_reg <= count_reg + 16'h0001;  // RULE_22
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Pins are asynchronous; edges are judged on the second stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= module_io_pin_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;  // RULE_01
        end
    end

    // ==========================================================
    // Modules
    // ==========================================================
    for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
        // Write strobes for this module
        always_comb begin
            wr_w[i].data = pwdata[7:0];
            wr_w[i].mode = wr_fire & mod_hit(paddr) & (mod_idx(paddr) == i)
                         & (paddr[3:2] == SEL_MODE);
            wr_w[i].low  = wr_fire & mod_hit(paddr) & (mod_idx(paddr) == i)
                         & (paddr[3:2] == SEL_CMP_LOW);
            wr_w[i].high = wr_fire & mod_hit(paddr) & (mod_idx(paddr) == i)
                         & (paddr[3:2] == SEL_CMP_HIGH);
        end
        assign irq_en_w[i] = mode_w[i].module_irq_enable;

        cacc_cell u_cell (
            .pclk        (pclk),
            .presetn     (presetn),
            .count       (count_reg),
            .low_wrap    (low_wrap),
            .pin_now     (sync2_reg[i]),
            .pin_prev    (prev_reg[i]),
            .wr          (wr_w[i]),
            .mode_reg    (mode_w[i]),
            .low_reg     (low_w[i]),
            .high_reg    (high_w[i]),
            .hit         (hit_w[i]),
            .captured    (cap_w[i]),
            .event_hit   (evt_w[i]),
            .pin_out_reg (module_io_pin_out[i]),
            .pin_oe_reg  (module_io_pin_oe[i])
        );
    end

    // ==========================================================
    // Event flags and interrupt request
    // ==========================================================
    // Write one to clear; a new event in the same cycle wins
    assign flag_clr   = (wr_fire && paddr == ADDR_FLAGS) ? pwdata[NUM_MODULES-1:0] : '0;
    assign flags_next = (flags_reg & ~flag_clr) | evt_w;  // RULE_20

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            irq_reg   <= |(flags_reg & irq_en_w);  // RULE_03 RULE_04
        end
    end

    // ==========================================================
    // Watchdog
    // ==========================================================
    // Internal reset pulse only; the block itself is not reset by it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdog_reg <= 1'b0;
        else
            wdog_reg <= wdt_en_reg & hit_w[WDT_MODULE]
                      & mode_w[WDT_MODULE].compare_hit_enable;  // RULE_16 RULE_17
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign irq_req        = irq_reg;
    assign watchdog_reset = wdog_reg;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_count_shared_step: assert property (  // RULE_22
        run_reg && !count_wr |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not advance by one");

    a_flag_sticky_hold: assert property (  // RULE_20
        flags_reg[1] && !flag_clr[1] |=> flags_reg[1])
        else $error("event flag dropped without clear");

    a_flag_set_wins: assert property (  // RULE_20
        evt_w[1] && flag_clr[1] |=> flags_reg[1])
        else $error("event lost against clear");

    a_irq_follows_flag: assert property (  // RULE_03
        (flags_reg[1] && irq_en_w[1]) |=> irq_req)
        else $error("interrupt request missing");

    a_irq_needs_cause: assert property (  // RULE_04
        !(|(flags_reg & irq_en_w)) |=> !irq_req)
        else $error("interrupt request without cause");

    a_capture_loads_count: assert property (  // RULE_02
        cap_w[1] && !wr_w[1].low && !wr_w[1].high
        |=> {high_w[1], low_w[1]} == $past(count_reg))
        else $error("capture did not load counter");

    a_low_write_clears: assert property (  // RULE_05
        wr_w[0].low |=> !mode_w[0].comparator_enable)
        else $error("low byte write kept comparator on");

    a_high_write_sets: assert property (  // RULE_06
        wr_w[0].high |=> mode_w[0].comparator_enable)
        else $error("high byte write left comparator off");

    a_toggle_on_hit: assert property (  // RULE_10
        hit_w[2] && mode_w[2].output_flip_enable && mode_w[2].compare_hit_enable
        && !mode_w[2].pwm_enable
        |=> module_io_pin_out[2] != $past(module_io_pin_out[2]))
        else $error("output did not toggle on hit");

    a_pwm_level_duty: assert property (  // RULE_13
        mode_w[0].pwm_enable && mode_w[0].comparator_enable
        |=> module_io_pin_out[0] == ($past(count_reg[7:0]) >= $past(low_w[0])))
        else $error("pwm level wrong");

    a_pwm_reload_wrap: assert property (  // RULE_14
        low_wrap && mode_w[0].pwm_enable && mode_w[0].comparator_enable
        && !wr_w[0].low && !cap_w[0] |=> low_w[0] == $past(high_w[0]))
        else $error("duty byte not reloaded at wrap");

    a_wdt_fires_reset: assert property (  // RULE_17
        wdt_en_reg && hit_w[WDT_MODULE] && mode_w[WDT_MODULE].compare_hit_enable
        |=> watchdog_reset ##1 !watchdog_reset [*2])
        else $error("watchdog reset pulse wrong");

    a_wdt_off_quiet: assert property (  // RULE_18
        !wdt_en_reg |=> !watchdog_reset)
        else $error("watchdog reset while disabled");

    a_apb_ready_once: assert property (
        setup |=> pready ##1 !pready)
        else $error("apb ready not single cycle");

    c_capture_seen: cover property (cap_w[1] ##1 flags_reg[1]);
    c_toggle_seen: cover property (hit_w[2] && mode_w[2].output_flip_enable);
    c_pwm_wrap_seen: cover property (low_wrap && mode_w[0].pwm_enable);
    c_wdt_reset_seen: cover property (watchdog_reset);
endmodule // cacc_top

// *** cacc_pin_model.sv ***
// ==========================================================
// Far side: drives the module pins
// ==========================================================
module cacc_pin_model (
    // Clock
    input  wire logic       pclk,
    // Requested pin levels from the bench
    input  wire logic [4:0] level_req,
    // Pin levels seen by the block
    output logic [4:0]      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels change only after an edge, so the block never sees a half-cycle glitch
    initial pin = 5'h00;
    always @(posedge pclk) begin
        pin <= level_req;
    end
endmodule // cacc_pin_model

// *** cacc_top_tb.sv ***
// ==========================================================
// Testbench
// ==========================================================
module cacc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready, irq_req, watchdog_reset;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  pin_req, pin_in, pin_out, pin_oe;
    int          failures, checked, wdp;
    cacc_top i_cacc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
        .module_io_pin_oe(pin_oe), .irq_req(irq_req), .watchdog_reset(watchdog_reset));
    cacc_pin_model i_cacc_pin_model (.pclk(pclk), .level_req(pin_req), .pin(pin_in));
    // ==========================================================
    // Clock, reset and shared tasks
    // ==========================================================
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Pre-edge value of a registered pulse is what counts here
    always @(posedge pclk) begin
        if (watchdog_reset === 1'b1) wdp++;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", (a == 8'h2c) ? 32'h1 : 32'h0, {31'h0, pslverr});
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        idle(20000);
        failures++;
        stop_test;
    end
    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pin_req = 5'h00;
        failures = 0; checked = 0; wdp = 0;
        idle(2);
        presetn <= 1'b1;
        rchk("mode0", 8'h20, 32'h0);
        rchk("cmp_high0", 8'h28, 32'h0);
        rchk("unmapped", 8'h2c, 32'h0);
        $display("test reset done");
        // Comparator enable: direct, cleared by low, set by high
        apb(1'b1, 8'h20, 32'h40); rchk("ecmp_direct", 8'h20, 32'h40);
        apb(1'b1, 8'h24, 32'h11); rchk("ecmp_low", 8'h20, 32'h00);
        apb(1'b1, 8'h28, 32'h22); rchk("ecmp_high", 8'h20, 32'h40);
        apb(1'b1, 8'h20, 32'h00);
        $display("test comparator enable done");
        // Capture on module 1 with counter frozen at 1234
        apb(1'b1, 8'h08, 32'h34); apb(1'b1, 8'h0c, 32'h12);
        apb(1'b1, 8'h30, 32'h21);
        pin_req <= 5'h02; idle(8);
        rchk("cap_low", 8'h34, 32'h34); rchk("cap_high", 8'h38, 32'h12);
        rchk("flags", 8'h04, 32'h02); chk("irq", 32'h1, {31'h0, irq_req});
        apb(1'b1, 8'h08, 32'h56); pin_req <= 5'h00; idle(8);
        rchk("no_fall", 8'h34, 32'h34);
        apb(1'b1, 8'h30, 32'h31); pin_req <= 5'h02; idle(8);
        rchk("both_rise", 8'h34, 32'h56);
        apb(1'b1, 8'h08, 32'h78); pin_req <= 5'h00; idle(8);
        rchk("both_fall", 8'h34, 32'h78);
        // Clear lands in the very cycle of a new capture; the capture must win
        apb(1'b1, 8'h08, 32'h9a); pin_req <= 5'h02; idle(1);
        apb(1'b1, 8'h04, 32'h02); idle(3);
        rchk("flag_race", 8'h04, 32'h02);
        apb(1'b1, 8'h04, 32'h02); idle(3);
        rchk("flag_clr", 8'h04, 32'h0); chk("irq_off", 32'h0, {31'h0, irq_req});
        $display("test capture done");
        // Toggle output on module 2, low byte before high byte
        apb(1'b1, 8'h08, 32'h00); apb(1'b1, 8'h0c, 32'h00);
        apb(1'b1, 8'h44, 32'h10); apb(1'b1, 8'h48, 32'h00);
        apb(1'b1, 8'h40, 32'h4c);
        apb(1'b1, 8'h00, 32'h1); idle(30); apb(1'b1, 8'h00, 32'h0);
        rchk("cmp_flag", 8'h04, 32'h04);
        chk("toggle", 32'h1, {31'h0, pin_out[2]});
        chk("toggle_oe", 32'h1, {31'h0, pin_oe[2]});
        chk("irq_masked", 32'h0, {31'h0, irq_req});
        $display("test compare done");
        // PWM on module 0, duty 80 then reload 20 at wrap
        apb(1'b1, 8'h24, 32'h80); apb(1'b1, 8'h28, 32'h20); apb(1'b1, 8'h20, 32'h42);
        apb(1'b1, 8'h08, 32'h7f); idle(3);
        chk("pwm_below", 32'h0, {31'h0, pin_out[0]});
        apb(1'b1, 8'h08, 32'h80); idle(3);
        chk("pwm_equal", 32'h1, {31'h0, pin_out[0]});
        apb(1'b1, 8'h20, 32'h02); idle(3);
        chk("pwm_off", 32'h0, {31'h0, pin_oe[0]});
        apb(1'b1, 8'h20, 32'h42); apb(1'b1, 8'h08, 32'hfe);
        apb(1'b1, 8'h00, 32'h1); idle(4); apb(1'b1, 8'h00, 32'h0);
        rchk("pwm_reload", 8'h24, 32'h20);
        $display("test pwm done");
        // Watchdog on module 4, then with its enable cleared
        apb(1'b1, 8'h08, 32'h00); apb(1'b1, 8'h0c, 32'h00);
        apb(1'b1, 8'h64, 32'h05); apb(1'b1, 8'h68, 32'h00); apb(1'b1, 8'h60, 32'h48);
        apb(1'b1, 8'h10, 32'h1); apb(1'b1, 8'h00, 32'h1); idle(20);
        apb(1'b1, 8'h00, 32'h0);
        chk("wdt_fire", 32'h1, wdp);
        // Hold off by moving the compare value far ahead of the count
        apb(1'b1, 8'h08, 32'h00); apb(1'b1, 8'h64, 32'h00); apb(1'b1, 8'h68, 32'h40);
        apb(1'b1, 8'h00, 32'h1); idle(20); apb(1'b1, 8'h00, 32'h0);
        chk("wdt_hold", 32'h1, wdp);
        apb(1'b1, 8'h64, 32'h05); apb(1'b1, 8'h68, 32'h00);
        apb(1'b1, 8'h08, 32'h00); apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h1); idle(20); apb(1'b1, 8'h00, 32'h0);
        chk("wdt_off", 32'h1, wdp);
        $display("test watchdog done");
        stop_test;
    end
endmodule // cacc_top_tb
